// File: hw/sdpe_encoder.sv
// Overview of operation
// - Hold current low 15 us before pulse
// - Then drive high for encoded width
// - Speed-only pulse 30 us before direction
// - Speed pulses at once, direction when known
// - First pulse within 2 edges, rising only
// - Hysteresis suppression active from power-on
// - Direction suppression after 2 output pulses
// - Undirected speed pulses, any number, until direction known
// - One wrong-direction pulse after reversal; two if it meets a trigger edge with none pending
`timescale 1ns/1ps
`default_nettype none
`include "sdpe_defines.svh"

module sdpe_encoder
  import sdpe_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire sdpe_mag_t mag,
  output logic cur_high,
  output logic busy,
  output logic dir_suppr_active,
  output logic hyst_suppr_active
);

  localparam logic [14:0] PRE_CYC = 15'(`SDPE_PRE_LOW_CYC);
  localparam logic [14:0] SPEED_CYC = 15'(`SDPE_SPEED_CYC);
  localparam logic [14:0] CW_CYC = 15'(`SDPE_CW_CYC);
  localparam logic [14:0] CCW_CYC = 15'(`SDPE_CCW_CYC);

  sdpe_regs_t r_q;
  sdpe_regs_t r_d;
  logic trig;
  logic [14:0] width;

  always_comb
  begin
    r_d = r_q;
    // Hysteresis suppression needs no pulses; it is on from reset
    hyst_suppr_active = 1'b1;
    // Until the first pulse only rising edges count; later either edge triggers
    trig = r_q.started ? (mag.edge_rise | mag.edge_fall) : mag.edge_rise;
    unique case (r_q.kind)
      SDPE_KIND_CW: width = CW_CYC;
      SDPE_KIND_CCW: width = CCW_CYC;
      default: width = SPEED_CYC;
    endcase
    if (mag.edge_rise | mag.edge_fall)
    begin
      if (r_q.edges != 2'(`SDPE_START_EDGES))
      begin
        r_d.edges = r_q.edges + 2'h1;
      end
    end
    if (mag.dir_valid)
    begin
      if (r_q.dir_known && (mag.dir_ccw != r_q.last_ccw))
      begin
        // One pulse may still go out with the old sense
        r_d.wrong_pend = 1'b1;
      end
      r_d.dir_known = 1'b1;
      r_d.last_ccw = mag.dir_ccw;
    end
    unique case (r_q.st)
      SDPE_IDLE:
      begin
        if (trig)
        begin
          r_d.st = SDPE_PRE;
          r_d.cnt = PRE_CYC - 15'h1;
          r_d.cur_hi = 1'b0;
          r_d.started = 1'b1;
          // Kind is frozen at the edge so a mid-pulse direction change cannot alter width
          if (!r_q.dir_known)
          begin
            r_d.kind = SDPE_KIND_SPEED;
          end
          else if (r_q.wrong_pend)
          begin
            r_d.kind = r_q.last_ccw ? SDPE_KIND_CW : SDPE_KIND_CCW;
            // A reversal seen in this same cycle keeps its pending wrong pulse: set wins
            if (!(mag.dir_valid && (mag.dir_ccw != r_q.last_ccw)))
            begin
              r_d.wrong_pend = 1'b0;
            end
          end
          else
          begin
            r_d.kind = r_q.last_ccw ? SDPE_KIND_CCW : SDPE_KIND_CW;
          end
        end
      end
      SDPE_PRE:
      begin
        if (r_q.cnt == 15'h0)
        begin
          r_d.st = SDPE_HIGH;
          r_d.cnt = width - 15'h1;
          r_d.cur_hi = 1'b1;
        end
        else
        begin
          r_d.cnt = r_q.cnt - 15'h1;
        end
      end
      SDPE_HIGH:
      begin
        if (r_q.cnt == 15'h0)
        begin
          r_d.st = SDPE_IDLE;
          r_d.cur_hi = 1'b0;
          if (r_q.pulses != 2'(`SDPE_DIR_SUPPR_DELAY))
          begin
            r_d.pulses = r_q.pulses + 2'h1;
          end
        end
        else
        begin
          r_d.cnt = r_q.cnt - 15'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      r_q <= '{st: SDPE_IDLE, kind: SDPE_KIND_SPEED, default: '0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign cur_high = r_q.cur_hi;
  assign busy = (r_q.st != SDPE_IDLE);
  assign dir_suppr_active = (r_q.pulses == 2'(`SDPE_DIR_SUPPR_DELAY));

endmodule : sdpe_encoder
`default_nettype wire

// File: hw/sdpe_defines.svh
`ifndef SDPE_DEFINES_SVH
`define SDPE_DEFINES_SVH

// Clock period in picoseconds (200 MHz)
`define SDPE_CLK_PS 5000
// Typical interval lengths in nanoseconds
`define SDPE_PRE_LOW_NS 15000
`define SDPE_SPEED_NS 30000
`define SDPE_CW_NS 45000
`define SDPE_CCW_NS 90000
// Cycle counts derived from the typical figures
`define SDPE_PRE_LOW_CYC ((`SDPE_PRE_LOW_NS * 1000) / `SDPE_CLK_PS)
`define SDPE_SPEED_CYC ((`SDPE_SPEED_NS * 1000) / `SDPE_CLK_PS)
`define SDPE_CW_CYC ((`SDPE_CW_NS * 1000) / `SDPE_CLK_PS)
`define SDPE_CCW_CYC ((`SDPE_CCW_NS * 1000) / `SDPE_CLK_PS)
// Counter width: covers the longest count (18000)
`define SDPE_CNT_W 15
// Start-up figures
`define SDPE_START_EDGES 2
`define SDPE_HYST_SUPPR_DELAY 0
`define SDPE_DIR_SUPPR_DELAY 2
`define SDPE_WRONG_DIR_PULSES 1

`endif

// File: hw/sdpe_pkg.sv
package sdpe_pkg;
  typedef enum logic [2:0] {
    SDPE_IDLE = 3'b001,
    SDPE_PRE = 3'b010,
    SDPE_HIGH = 3'b100
  } sdpe_state_t;

  typedef enum logic [1:0] {
    SDPE_KIND_SPEED = 2'h0,
    SDPE_KIND_CW = 2'h1,
    SDPE_KIND_CCW = 2'h2
  } sdpe_kind_t;

  // Magnetic front-end inputs, already on the block clock
  typedef struct packed {
    logic edge_rise;
    logic edge_fall;
    logic dir_valid;
    logic dir_ccw;
  } sdpe_mag_t;

  typedef struct packed {
    sdpe_state_t st;
    sdpe_kind_t kind;
    logic [14:0] cnt;
    logic [1:0] edges;
    logic started;
    logic [1:0] pulses;
    logic dir_known;
    logic last_ccw;
    logic wrong_pend;
    logic cur_hi;
  } sdpe_regs_t;
endpackage : sdpe_pkg

// File: tb/sdpe_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sdpe_monitor
  import sdpe_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire sdpe_mag_t mag,
  input wire logic cur_high,
  input wire logic busy,
  input wire logic dir_suppr_active,
  input wire logic hyst_suppr_active
);
  logic [14:0] h_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Counting busy cycles spares long delays
  always_ff @(posedge clock or posedge rst)
    if (rst) h_q <= '0;
    else h_q <= busy ? h_q + 15'h1 : 15'h0;
  a_hyst_on: assert property (hyst_suppr_active) else $error("hyst");
  a_pre_low: assert property ($rose(cur_high) |-> h_q == 15'hbb8) else $error("pre");
  a_width_ok: assert property ($fell(cur_high) |-> h_q inside {15'h2328, 15'h2ee0, 15'h5208})
    else $error("width");
  a_busy_end: assert property ($fell(cur_high) |-> $fell(busy)) else $error("end");
  a_cur_busy: assert property (cur_high |-> busy) else $error("cur");
  a_take_rise: assert property (!busy && mag.edge_rise |=> busy) else $error("take");
  a_dir_keep: assert property (dir_suppr_active |=> dir_suppr_active) else $error("keep");
  a_dir_cause: assert property ($rose(dir_suppr_active) |-> !busy) else $error("dir");
endmodule : sdpe_monitor
bind sdpe_encoder sdpe_monitor u_mon (.clock(clock), .rst(rst), .mag(mag),
  .cur_high(cur_high), .busy(busy), .dir_suppr_active(dir_suppr_active),
  .hyst_suppr_active(hyst_suppr_active));
`default_nettype wire

// File: tb/sdpe_tcu.sv
`timescale 1ns/1ps
`default_nettype none
module sdpe_tcu
  import sdpe_pkg::*;
(
  input wire logic clock,
  input wire logic cur_high,
  output sdpe_kind_t kind,
  output logic [3:0] pulses = 4'h0
);
  logic [14:0] w_q = '0;
  // Thresholds sit midway between nominal widths
  always @(posedge clock)
    if (cur_high) w_q <= w_q + 15'h1;
    else if (w_q != 15'h0)
    begin
      w_q <= 15'h0;
      pulses <= pulses + 4'h1;
      kind <= w_q < 15'h1d4c ? SDPE_KIND_SPEED : w_q < 15'h34bc ? SDPE_KIND_CW : SDPE_KIND_CCW;
    end
endmodule : sdpe_tcu
`default_nettype wire

// File: tb/speed_direction_pulse_encoder_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module speed_direction_pulse_encoder_test
  import sdpe_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, cur_high, busy, dsa;
  sdpe_mag_t mag = '0;
  sdpe_kind_t kind;
  logic [3:0] pulses;
  int error_cnt = 0, checked = 0;
  initial forever #2.5 clock = ~clock;
  sdpe_encoder DUT (.clock(clock), .rst(rst), .mag(mag), .cur_high(cur_high), .busy(busy),
    .dir_suppr_active(dsa), .hyst_suppr_active());
  sdpe_tcu u_tcu (.clock(clock), .cur_high(cur_high), .kind(kind), .pulses(pulses));
  task print_verdict;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // One edge, then wait out the whole pulse
  task send(input logic r, input logic f);
    int n;
    @(posedge clock) #1 mag.edge_rise = r;
    mag.edge_fall = f;
    @(posedge clock) #1 mag.edge_rise = 1'b0;
    mag.edge_fall = 1'b0;
    for (n = 0; busy !== 1'b0 && n < 30000; n++) @(posedge clock) #1;
    error_cnt += (n == 30000);
    if (n == 30000) print_verdict();
    @(posedge clock) #1;
  endtask : send
  task first_pulse;
    send(1'b0, 1'b1);
    `CHK(pulses, 4'h0)
    send(1'b1, 1'b0);
    `CHK(kind, SDPE_KIND_SPEED)
    `CHK(dsa, 1'b0)
  endtask : first_pulse
  task reversal;
    mag.dir_valid = 1'b1;
    send(1'b0, 1'b1);
    `CHK(kind, SDPE_KIND_CW)
    `CHK(dsa, 1'b1)
    mag.dir_ccw = 1'b1;
    send(1'b1, 1'b0);
    `CHK(kind, SDPE_KIND_CW)
    send(1'b0, 1'b1);
    `CHK(kind, SDPE_KIND_CCW)
  endtask : reversal
  initial
  begin
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    first_pulse();
    reversal();
    print_verdict();
  end
endmodule : speed_direction_pulse_encoder_test
`default_nettype wire
